// ---- egs_pkg.sv ----
/*
 * egs_pkg: constants of the electronic gear scaler, register map, field positions,
 * reset values, modes and arithmetic limits.
 * assumes: one 100 MHz clock, word-aligned byte addresses on the plain register port.
 */
// What this block does
// - in position and full-closed modes the host position command is multiplied by numerator over denominator.
// - in speed and torque modes the encoder pulse count is divided by the gear ratio to give feedback in command units.
// - a zero numerator setting is replaced by the encoder resolution, 131072 for 17-bit or 1048576 for 20-bit.
// - the zero-numerator substitution also holds in full-closed mode.
// - an effective ratio outside 1/1000 to 1000 inclusive raises the parameter-setting alarm 93.0.
// - with a zero numerator each command is scaled by encoder resolution over a denominator of 1 to 1073741824.
// - with a numerator of 1 to 1073741824 each command is scaled by numerator over denominator.
`default_nettype none
package egs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_NUM_OFS = 8'h00;
    localparam logic [7:0] REG_DEN_OFS = 8'h04;
    localparam logic [7:0] REG_CTRL_OFS = 8'h08;
    localparam logic [7:0] REG_STAT_OFS = 8'h0c;
    localparam logic [7:0] REG_MASK_OFS = 8'h10;
    localparam logic [7:0] REG_STATE_OFS = 8'h14;
    localparam logic [7:0] REG_EFFNUM_OFS = 8'h18;
    localparam logic [7:0] REG_ALARM_OFS = 8'h1c;
    localparam logic [7:0] REG_SMOOTH_OFS = 8'h20;
    localparam logic [7:0] REG_FIR_OFS = 8'h24;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ENC20_BIT = 2;
    // status and mask fields
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_POS_BIT = 1;
    localparam int STAT_FB_BIT = 2;
    localparam int STAT_W = 3;
    // live state fields
    localparam int STATE_OK_BIT = 0;
    localparam int STATE_BUSY_BIT = 1;
    // reset values
    localparam logic [30:0] NUM_RST = 31'h0000_0000;
    localparam logic [30:0] DEN_RST = 31'h0000_0001;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
    localparam logic [15:0] SMOOTH_RST = 16'h0000;
    // settings limits and encoder resolutions
    localparam logic [30:0] SET_MAX = 31'h4000_0000;
    localparam logic [30:0] RES_17BIT = 31'h0002_0000;
    localparam logic [30:0] RES_20BIT = 31'h0010_0000;
    localparam logic [9:0] RATIO_LIMIT = 10'h3e8;
    // alarm code 93.0 as main number and sub number
    localparam logic [15:0] ALARM_CODE = 16'h5d00;
    // divider length in steps
    localparam logic [6:0] DIV_STEPS = 7'h40;
    // control modes
    typedef enum logic [1:0] {
        EGS_MODE_POS = 2'b00,
        EGS_MODE_SPEED = 2'b01,
        EGS_MODE_TORQUE = 2'b10,
        EGS_MODE_FULLCL = 2'b11
    } egs_mode_t;
    // scaler states
    typedef enum logic [1:0] {
        EGS_IDLE = 2'b00,
        EGS_DIV = 2'b01,
        EGS_DONE = 2'b10
    } egs_state_t;
endpackage : egs_pkg
`default_nettype wire

// ---- egs_scaler.sv ----
/*
 * egs_scaler: electronic gear scaler with register port, sticky events, mask and
 * interrupt, and a sequential signed divider shared by command and feedback paths.
 * assumes: inputs synchronous to sys_clk, synchronous active-high reset, the
 * host holds a request until ready is seen high in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module egs_scaler #(
    parameter int CMD_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // host position command
    input wire logic cmd_valid,
    input wire logic [CMD_W-1:0] cmd_delta,
    output logic cmd_ready,
    // motor encoder pulses
    input wire logic enc_valid,
    input wire logic [CMD_W-1:0] enc_delta,
    output logic enc_ready,
    // scaled outputs
    output logic pos_valid,
    output logic [CMD_W-1:0] pos_out,
    output logic fb_valid,
    output logic [CMD_W-1:0] fb_out,
    // alarm and interrupt
    output logic alarm,
    output logic irq
);
    // widths the datapath cannot serve are refused at elaboration
    if (CMD_W < 8 || CMD_W > 32) begin : g_bad_cmd_w
        $error("egs_scaler: CMD_W must lie in 8..32");
    end
    if (egs_pkg::DIV_STEPS != 7'h40) begin : g_bad_steps
        $error("egs_scaler: divider needs one step per dividend bit");
    end

    logic [30:0] num_r;
    logic [30:0] den_r;
    logic [2:0] ctrl_r;
    logic [egs_pkg::STAT_W-1:0] stat_r;
    logic [egs_pkg::STAT_W-1:0] mask_r;
    logic [15:0] smooth_r;
    logic [15:0] fir_r;
    logic [31:0] rdata_r;
    egs_pkg::egs_state_t state_r;
    logic [6:0] step_r;
    logic [63:0] dvd_r;
    logic [31:0] rem_r;
    logic [30:0] dvr_r;
    logic neg_r;
    logic fb_job_r;
    logic [31:0] carry_r;
    logic keep_r;
    logic [CMD_W-1:0] pos_r;
    logic [CMD_W-1:0] fb_r;
    logic pos_v_r;
    logic fb_v_r;

    egs_pkg::egs_mode_t mode;
    logic fb_mode;
    logic [30:0] num_eff;
    logic [40:0] num_x1000;
    logic [40:0] den_x1000;
    logic ratio_ok;
    logic idle;
    logic take_cmd;
    logic take_enc;
    logic take;
    logic [63:0] delta_ext;
    logic [63:0] mul_ext;
    logic [63:0] product;
    logic [63:0] dividend;
    logic [63:0] mag;
    logic [31:0] rem_sh;
    logic rem_ge;
    logic [63:0] q_final;
    logic [31:0] carry_nxt;
    logic [egs_pkg::STAT_W-1:0] ev;
    logic cfg_wr;

    assign mode = egs_pkg::egs_mode_t'(ctrl_r[egs_pkg::CTRL_MODE_LSB +: 2]);
    assign fb_mode = (mode == egs_pkg::EGS_MODE_SPEED) || (mode == egs_pkg::EGS_MODE_TORQUE);

    // zero numerator takes the encoder resolution in every mode
    always_comb begin
        if (num_r == 31'h0) begin
            num_eff = ctrl_r[egs_pkg::CTRL_ENC20_BIT] ? egs_pkg::RES_20BIT : egs_pkg::RES_17BIT;
        end else begin
            num_eff = num_r;
        end
    end

    // ratio must stay within 1/1000 .. 1000 inclusive
    assign num_x1000 = {10'h0, num_eff} * {31'h0, egs_pkg::RATIO_LIMIT};
    assign den_x1000 = {10'h0, den_r} * {31'h0, egs_pkg::RATIO_LIMIT};
    assign ratio_ok = (den_r != 31'h0) && (num_x1000 >= {10'h0, den_r})
        && ({10'h0, num_eff} <= den_x1000);
    assign alarm = !ratio_ok;

    // requests are served only by the path of the current mode and a valid ratio
    assign idle = (state_r == egs_pkg::EGS_IDLE);
    assign cmd_ready = idle && ratio_ok && !fb_mode;
    assign enc_ready = idle && ratio_ok && fb_mode;
    assign take_cmd = cmd_valid && cmd_ready;
    assign take_enc = enc_valid && enc_ready;
    assign take = take_cmd || take_enc;
    // a write to numerator, denominator or control changes the ratio or the path
    assign cfg_wr = reg_wr && (reg_addr == egs_pkg::REG_NUM_OFS || reg_addr == egs_pkg::REG_DEN_OFS
        || reg_addr == egs_pkg::REG_CTRL_OFS);

    // command times numerator over denominator, pulses times denominator over numerator
    always_comb begin
        if (fb_mode) begin
            delta_ext = {{(64-CMD_W){enc_delta[CMD_W-1]}}, enc_delta};
            mul_ext = {33'h0, den_r};
        end else begin
            delta_ext = {{(64-CMD_W){cmd_delta[CMD_W-1]}}, cmd_delta};
            mul_ext = {33'h0, num_eff};
        end
        product = delta_ext * mul_ext;
        dividend = product + {32'h0, carry_r};
        mag = dividend[63] ? (64'h0 - dividend) : dividend;
    end

    // one restoring step per clock
    assign rem_sh = {rem_r[30:0], dvd_r[63]};
    assign rem_ge = rem_sh >= {1'b0, dvr_r};

    // floor division keeps a non-negative remainder for the next request
    always_comb begin
        if (!neg_r) begin
            q_final = dvd_r;
            carry_nxt = rem_r;
        end else if (rem_r == 32'h0) begin
            q_final = 64'h0 - dvd_r;
            carry_nxt = 32'h0;
        end else begin
            q_final = 64'h0 - dvd_r - 64'h1;
            carry_nxt = {1'b0, dvr_r} - rem_r;
        end
    end

    // scaler sequence
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= egs_pkg::EGS_IDLE;
            step_r <= 7'h0;
            dvd_r <= 64'h0;
            rem_r <= 32'h0;
            dvr_r <= 31'h1;
            neg_r <= 1'b0;
            fb_job_r <= 1'b0;
        end else begin
            case (state_r)
                egs_pkg::EGS_IDLE: begin
                    if (take) begin
                        dvd_r <= mag;
                        rem_r <= 32'h0;
                        dvr_r <= fb_mode ? num_eff : den_r;
                        neg_r <= dividend[63];
                        fb_job_r <= fb_mode;
                        step_r <= 7'h0;
                        state_r <= egs_pkg::EGS_DIV;
                    end
                end
                egs_pkg::EGS_DIV: begin
                    rem_r <= rem_ge ? (rem_sh - {1'b0, dvr_r}) : rem_sh;
                    dvd_r <= {dvd_r[62:0], rem_ge};
                    step_r <= step_r + 7'h1;
                    if (step_r == egs_pkg::DIV_STEPS - 7'h1) begin
                        state_r <= egs_pkg::EGS_DONE;
                    end
                end
                egs_pkg::EGS_DONE: begin
                    state_r <= egs_pkg::EGS_IDLE;
                end
                default: begin
                    state_r <= egs_pkg::EGS_IDLE;
                end
            endcase
        end
    end

    // a remainder belongs to the ratio and path it was made with, so numerator, denominator and control writes drop it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            carry_r <= 32'h0;
            keep_r <= 1'b0;
        end else if (cfg_wr) begin
            carry_r <= 32'h0;
            keep_r <= 1'b0;
        end else begin
            if (take) begin
                keep_r <= 1'b1;
            end
            if (state_r == egs_pkg::EGS_DONE && keep_r) begin
                carry_r <= carry_nxt;
            end
        end
    end

    // result registers and one-cycle valid pulses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pos_r <= '0;
            fb_r <= '0;
            pos_v_r <= 1'b0;
            fb_v_r <= 1'b0;
        end else begin
            pos_v_r <= (state_r == egs_pkg::EGS_DONE) && !fb_job_r;
            fb_v_r <= (state_r == egs_pkg::EGS_DONE) && fb_job_r;
            if (state_r == egs_pkg::EGS_DONE && !fb_job_r) begin
                pos_r <= q_final[CMD_W-1:0];
            end
            if (state_r == egs_pkg::EGS_DONE && fb_job_r) begin
                fb_r <= q_final[CMD_W-1:0];
            end
        end
    end
    assign pos_valid = pos_v_r;
    assign pos_out = pos_r;
    assign fb_valid = fb_v_r;
    assign fb_out = fb_r;

    // settings written by software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            num_r <= egs_pkg::NUM_RST;
            den_r <= egs_pkg::DEN_RST;
            ctrl_r <= egs_pkg::CTRL_RST;
            mask_r <= egs_pkg::MASK_RST;
            smooth_r <= egs_pkg::SMOOTH_RST;
            fir_r <= egs_pkg::SMOOTH_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                egs_pkg::REG_NUM_OFS: begin
                    if (reg_wdata[30:0] <= egs_pkg::SET_MAX && reg_wdata[31] == 1'b0) begin
                        num_r <= reg_wdata[30:0];
                    end
                end
                egs_pkg::REG_DEN_OFS: begin
                    if (reg_wdata[30:0] <= egs_pkg::SET_MAX && reg_wdata[31] == 1'b0
                        && reg_wdata[30:0] != 31'h0) begin
                        den_r <= reg_wdata[30:0];
                    end
                end
                egs_pkg::REG_CTRL_OFS: begin
                    ctrl_r <= reg_wdata[2:0];
                end
                egs_pkg::REG_MASK_OFS: begin
                    mask_r <= reg_wdata[egs_pkg::STAT_W-1:0];
                end
                egs_pkg::REG_SMOOTH_OFS: begin
                    smooth_r <= reg_wdata[15:0];
                end
                egs_pkg::REG_FIR_OFS: begin
                    fir_r <= reg_wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    always_comb begin
        ev = '0;
        ev[egs_pkg::STAT_ALARM_BIT] = !ratio_ok;
        ev[egs_pkg::STAT_POS_BIT] = (state_r == egs_pkg::EGS_DONE) && !fb_job_r;
        ev[egs_pkg::STAT_FB_BIT] = (state_r == egs_pkg::EGS_DONE) && fb_job_r;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_r <= '0;
        end else if (reg_wr && reg_addr == egs_pkg::REG_STAT_OFS) begin
            stat_r <= (stat_r & ~reg_wdata[egs_pkg::STAT_W-1:0]) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end
    assign irq = |(stat_r & mask_r);

    // read data stands the cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                egs_pkg::REG_NUM_OFS: rdata_r <= {1'b0, num_r};
                egs_pkg::REG_DEN_OFS: rdata_r <= {1'b0, den_r};
                egs_pkg::REG_CTRL_OFS: rdata_r <= {29'h0, ctrl_r};
                egs_pkg::REG_STAT_OFS: rdata_r <= {29'h0, stat_r};
                egs_pkg::REG_MASK_OFS: rdata_r <= {29'h0, mask_r};
                egs_pkg::REG_STATE_OFS: rdata_r <= {30'h0, !idle, ratio_ok};
                egs_pkg::REG_EFFNUM_OFS: rdata_r <= {1'b0, num_eff};
                egs_pkg::REG_ALARM_OFS: rdata_r <= {16'h0, ratio_ok ? 16'h0 : egs_pkg::ALARM_CODE};
                egs_pkg::REG_SMOOTH_OFS: rdata_r <= {16'h0, smooth_r};
                egs_pkg::REG_FIR_OFS: rdata_r <= {16'h0, fir_r};
                default: rdata_r <= 32'h0;
            endcase
        end else begin
            rdata_r <= 32'h0;
        end
    end
    assign reg_rdata = rdata_r;
endmodule : egs_scaler
`default_nettype wire

// ---- egs_scaler_asserts.sv ----
/* egs_scaler_asserts: port checker of the gear scaler.
   assumes: bound to egs_scaler, one clock, synchronous reset high. */
`timescale 1ns/1ps
`default_nettype none
module egs_scaler_asserts #(
    parameter int CMD_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register read
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // handshakes and results
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic enc_valid,
    input wire logic enc_ready,
    input wire logic pos_valid,
    input wire logic [CMD_W-1:0] pos_out,
    input wire logic fb_valid,
    input wire logic [CMD_W-1:0] fb_out,
    input wire logic alarm
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    AST_POS_LAT: assert property (cmd_valid && cmd_ready |-> ##66 pos_valid)
        else $error("position result not on time");
    AST_POS_BUSY: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*8])
        else $error("command taken while busy");
    AST_FB_LAT: assert property (enc_valid && enc_ready |-> ##66 fb_valid)
        else $error("feedback result not on time");
    AST_FB_QUIET: assert property (enc_valid && enc_ready |=> !fb_valid [*8])
        else $error("feedback result too early");
    AST_ALARM_STOP: assert property (alarm |-> !cmd_ready && !enc_ready)
        else $error("request accepted with bad ratio");
    AST_ONE_PATH: assert property (!(cmd_ready && enc_ready))
        else $error("both paths ready");
    AST_POS_HOLD: assert property ($changed(pos_out) |-> pos_valid)
        else $error("position output changed without valid");
    AST_FB_HOLD: assert property ($changed(fb_out) |-> fb_valid)
        else $error("feedback output changed without valid");
    AST_ALARM_CODE: assert property (reg_rd && reg_addr == egs_pkg::REG_ALARM_OFS |=>
        reg_rdata == ($past(alarm) ? {16'h0000, egs_pkg::ALARM_CODE} : 32'h0))
        else $error("alarm code read wrong");
    C_POS: cover property (pos_valid);
    C_FB: cover property (fb_valid);
    C_ALARM_CLR: cover property ($fell(alarm));
endmodule : egs_scaler_asserts
`default_nettype wire

// ---- egs_host_model.sv ----
/* egs_host_model: requester that hands one delta over a valid/ready handshake.
   assumes: caller enters send just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module egs_host_model #(
    parameter int CMD_W = 32
) (
    // clock
    input wire logic sys_clk,
    // request
    output var logic req_valid,
    output var logic [CMD_W-1:0] req_data,
    input wire logic req_ready
);
    initial begin
        req_valid = 1'b0;
        req_data = '0;
    end
    // gap sets how slow the requester is; data is scrambled once released
    task automatic send(input logic [CMD_W-1:0] d, input int gap, output bit ok);
        ok = 1'b0;
        repeat (gap) @(posedge sys_clk);
        req_valid <= 1'b1;
        req_data <= d;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge sys_clk);
            ok = (req_ready === 1'b1);
        end
        req_valid <= 1'b0;
        req_data <= ~d;
    endtask : send
endmodule : egs_host_model
`default_nettype wire

// ---- tb_top.sv ----
/* tb_top: self-checking bench of the gear scaler.
   assumes: egs_pkg, egs_scaler, egs_host_model and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CMD_W = 32;
    localparam logic [31:0] RN [8] = '{32'h1, 32'h1, 32'h3e8, 32'h3e9, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] RD [8] = '{32'h3e8, 32'h3e9, 32'h1, 32'h1, 32'h84, 32'h83, 32'h419,
        32'h418};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic cmd_valid, cmd_ready, enc_valid, enc_ready, pos_valid, fb_valid, alarm, irq;
    logic [CMD_W-1:0] cmd_delta, enc_delta, pos_out, fb_out;
    int error_cnt = 0;
    int compares = 0;
    longint cy = 0;
    always #5 sys_clk = ~sys_clk;
    egs_scaler #(.CMD_W(CMD_W)) i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .cmd_ready(cmd_ready),
        .enc_valid(enc_valid), .enc_delta(enc_delta), .enc_ready(enc_ready),
        .pos_valid(pos_valid), .pos_out(pos_out), .fb_valid(fb_valid), .fb_out(fb_out),
        .alarm(alarm), .irq(irq));
    egs_host_model #(.CMD_W(CMD_W)) i_host (.sys_clk(sys_clk), .req_valid(cmd_valid),
        .req_data(cmd_delta), .req_ready(cmd_ready));
    egs_host_model #(.CMD_W(CMD_W)) i_enc (.sys_clk(sys_clk), .req_valid(enc_valid),
        .req_data(enc_delta), .req_ready(enc_ready));
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
        @(posedge sys_clk);
    endtask : rdc
    task automatic cfg(input logic [31:0] n, input logic [31:0] d, input logic [31:0] c);
        wr(egs_pkg::REG_NUM_OFS, n);
        wr(egs_pkg::REG_DEN_OFS, d);
        wr(egs_pkg::REG_CTRL_OFS, c);
        cy = 0;
    endtask : cfg
    // floor division, remainder kept for the next request
    function automatic longint fd(input longint n, input longint v);
        longint q;
        q = n / v;
        if (n - q * v < 0) q = q - 1;
        cy = n - q * v;
        return q;
    endfunction : fd
    task automatic go(input bit f, input logic [31:0] d, input longint m, input longint v);
        longint q;
        bit ok;
        int i;
        q = fd(longint'($signed(d)) * m + cy, v);
        if (f) i_enc.send(d, 0, ok);
        else i_host.send(d, 2, ok);
        for (i = 0; i < 100 && (f ? fb_valid : pos_valid) !== 1'b1; i++) @(negedge sys_clk);
        if (!ok || i == 100) begin
            error_cnt++;
            report_and_stop;
        end
        chk("result", q[31:0], f ? fb_out : pos_out);
        @(posedge sys_clk);
    endtask : go
    task automatic t_reset;
        chk("alarm", 32'h1, {31'h0, alarm});
        chk("irq", 32'h0, {31'h0, irq});
        chk("pos_out", 32'h0, pos_out);
        chk("fb_out", 32'h0, fb_out);
        rdc("effnum", egs_pkg::REG_EFFNUM_OFS, 32'h2_0000);
        $display("done reset");
    endtask : t_reset
    task automatic t_ratio;
        logic ok;
        for (int i = 0; i < 8; i++) begin
            ok = ~i[0];
            cfg(RN[i], RD[i], i > 5 ? 32'h7 : 32'h0);
            chk("alarm", {31'h0, ~ok}, {31'h0, alarm});
            rdc("code", egs_pkg::REG_ALARM_OFS, ok ? 32'h0 : 32'h5d00);
            rdc("effnum", egs_pkg::REG_EFFNUM_OFS,
                RN[i] != 0 ? RN[i] : i > 5 ? 32'h10_0000 : 32'h2_0000);
        end
        $display("done ratio");
    endtask : t_ratio
    task automatic t_pos;
        cfg(32'h3, 32'h7, 32'h0);
        for (int i = 0; i < 5; i++) go(0, i == 3 ? 32'hffff_fffb : 32'h1, 3, 7);
        $display("done position");
    endtask : t_pos
    task automatic t_irq;
        wr(egs_pkg::REG_STAT_OFS, 32'h7);
        wr(egs_pkg::REG_MASK_OFS, 32'h2);
        go(0, 32'h4, 3, 7);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("status", egs_pkg::REG_STAT_OFS, 32'h2);
        wr(egs_pkg::REG_STAT_OFS, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        wr(egs_pkg::REG_MASK_OFS, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        $display("done irq");
    endtask : t_irq
    task automatic t_full;
        cfg(32'h0, 32'h7d0, 32'h7);
        for (int i = 0; i < 3; i++) go(0, i == 2 ? 32'h3 : 32'h1, 32'h10_0000, 32'h7d0);
        $display("done full closed");
    endtask : t_full
    task automatic t_fb;
        for (int m = 1; m < 3; m++) begin
            cfg(32'h4, 32'h3, m);
            for (int i = 0; i < 3; i++) go(1, i == 2 ? 32'hffff_ffff : 32'h5, 3, 4);
        end
        $display("done feedback");
    endtask : t_fb
    task automatic t_smooth;
        wr(egs_pkg::REG_SMOOTH_OFS, 32'h1234);
        wr(egs_pkg::REG_FIR_OFS, 32'h00ff);
        rdc("smooth", egs_pkg::REG_SMOOTH_OFS, 32'h1234);
        rdc("fir", egs_pkg::REG_FIR_OFS, 32'h00ff);
        $display("done smoothing");
    endtask : t_smooth
    task automatic t_limits;
        wr(egs_pkg::REG_DEN_OFS, 32'h0);
        wr(egs_pkg::REG_NUM_OFS, 32'h4000_0001);
        rdc("den", egs_pkg::REG_DEN_OFS, 32'h3);
        rdc("num", egs_pkg::REG_NUM_OFS, 32'h4);
        wr(egs_pkg::REG_NUM_OFS, 32'h4000_0000);
        chk("alarm", 32'h1, {31'h0, alarm});
        rdc("state", egs_pkg::REG_STATE_OFS, 32'h0);
        wr(egs_pkg::REG_DEN_OFS, 32'h4000_0000);
        rdc("den", egs_pkg::REG_DEN_OFS, 32'h4000_0000);
        rdc("state", egs_pkg::REG_STATE_OFS, 32'h1);
        $display("done limits");
    endtask : t_limits
    task automatic t_rerst;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
    endtask : t_rerst
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_ratio;
        t_pos;
        t_irq;
        t_full;
        t_fb;
        t_smooth;
        t_limits;
        t_rerst;
        report_and_stop;
    end
endmodule : tb_top
bind egs_scaler egs_scaler_asserts #(.CMD_W(CMD_W)) i_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .enc_valid(enc_valid), .enc_ready(enc_ready),
    .pos_valid(pos_valid), .pos_out(pos_out), .fb_valid(fb_valid), .fb_out(fb_out),
    .alarm(alarm));
`default_nettype wire
